// [design/adc_seq_pkg.sv]
// Purpose: Shared constants for the converter link, both ends.
// Assumes: 20 MHz system clock on both ends.
// Notes: Cycle counts derive from times printed in ns or ms.
package adc_seq_pkg;
  // Clock and printed times
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned CONV_TYP_NS = 3200;
  localparam int unsigned CONV_MAX_NS = 3700;
  localparam int unsigned ACQ_MIN_NS = 2010;
  localparam int unsigned EARLY_LOW_NS = 100;
  localparam int unsigned WAKE_MS = 80;
  localparam int unsigned RATE_SPS = 175_000;

  // Derived counts: least and longest times and the period round up, typical and early-low times round down
  localparam int unsigned CONV_TYP_CYC = CONV_TYP_NS / CLK_NS;
  localparam int unsigned CONV_MAX_CYC = (CONV_MAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ACQ_MIN_CYC = (ACQ_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned EARLY_LOW_CYC = EARLY_LOW_NS / CLK_NS;
  localparam int unsigned PERIOD_CYC = (CLK_HZ + RATE_SPS - 1) / RATE_SPS;
  localparam int unsigned WAKE_CYC_DEF = WAKE_MS * (CLK_HZ / 1000);
  localparam int unsigned GAP_CYC = (PERIOD_CYC > CONV_MAX_CYC + ACQ_MIN_CYC)
    ? PERIOD_CYC : CONV_MAX_CYC + ACQ_MIN_CYC;
  localparam int unsigned SCK_HALF_CYC = 8;

  // Widths
  localparam int unsigned RESULT_W = 16;
  localparam int unsigned CFG_W = 7;
  localparam int unsigned WAKE_W = 21;
  localparam int unsigned CNT_W = 8;

  // Configuration word fields, first sent bit is the highest
  localparam int unsigned CFG_SD = 6;
  localparam int unsigned CFG_OS = 5;
  localparam int unsigned CFG_HI = 4;
  localparam int unsigned CFG_LO = 3;
  localparam int unsigned CFG_COM = 2;
  localparam int unsigned CFG_UNI = 1;
  localparam int unsigned CFG_SLP = 0;

  // Values after reset, plus the bipolar flip mask
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic [RESULT_W-1:0] BIPOLAR_FLIP = 16'h8000;
  localparam logic [CNT_W-1:0] PER_CNT_RESET = 8'hff;
endpackage

// [design/adc_link_if.sv]
// Purpose: Pin bundle between converter and its controller.
// Assumes: Released result line shows the inverse of the last bit.
// Notes: Output enable is low while the converter drives.
`timescale 1ns/10ps
interface adc_link_if;
  logic sample_trigger_n;
  logic shift_clk;
  logic serial_config_in;
  logic result_bit;
  logic result_oe_n;
  wire serial_result_out;

  // Released line shows the inverse, so an early sample shows up wrong
  assign serial_result_out = result_oe_n ? ~result_bit : result_bit;

  modport device (
    input sample_trigger_n,
    input shift_clk,
    input serial_config_in,
    output result_bit,
    output result_oe_n
  );
  modport host (
    output sample_trigger_n,
    output shift_clk,
    output serial_config_in,
    input serial_result_out
  );
endinterface

// [design/adc_device_end.sv]
// Purpose: Converter end: conversion timing, power states, serial port.
// Assumes: Link pins come from another domain; all pass two flops.
// Notes: The analog value is a straight code supplied by the user side.
//
// How it works
// R01: Trigger rising edge starts a conversion.
// R02: Edges during conversion are ignored.
// R03: Low trigger after conversion opens serial port.
// R04: Conversion takes typical time, host allows maximum.
// R05: Throughput limit bounds trigger rate.
// R06: Trigger high at end enters nap.
// R07: Trigger low at end shows MSB, stays up.
// R08: Host drops trigger early or after end.
// R09: Early low: output held low until conversion end.
// R10: Sleep bit set puts device to sleep.
// R11: Host waits wake-up time after sleep release.
// R12: Shift pins held still, ignored when busy.
// R13: Other bus traffic avoids conversion period.
// R14: Seven-bit word, fixed order, for next conversion.
// R15: Host allows acquisition time before next trigger.
// R16: Host does dummy conversion after power-up.
// R17: Config sampled on rise, result on fall.
// R18: MSB first; output released on trigger high.
`timescale 1ns/10ps
module adc_device_end
  import adc_seq_pkg::*;
#(
  parameter int unsigned WAKE_CYC = WAKE_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  adc_link_if.device link,
  input wire logic [RESULT_W-1:0] analog_code,
  output logic [CFG_W-1:0] active_cfg,
  output logic converting,
  output logic napping,
  output logic sleeping,
  output logic awake,
  output logic conv_done
);

  typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_NAP, ST_SLEEP} dev_state_t;

  // Output code format by polarity
  function automatic logic [RESULT_W-1:0] format_code(
    input logic [RESULT_W-1:0] code,
    input logic polarity_select
  );
    format_code = polarity_select ? code : code ^ BIPOLAR_FLIP;
  endfunction

  // Two-flop synchronisers plus one history stage for edges
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] prev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      prev <= 3'h0;
    end else begin
      sync1 <= {link.sample_trigger_n, link.shift_clk, link.serial_config_in};
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  logic trig_hi;
  logic trig_rise;
  logic sck_rise;
  logic sck_fall;
  logic cfg_bit;

  assign trig_hi = sync2[2];
  assign trig_rise = sync2[2] & ~prev[2];
  assign sck_rise = sync2[1] & ~prev[1];
  assign sck_fall = ~sync2[1] & prev[1];
  assign cfg_bit = sync2[0];

  dev_state_t state;
  dev_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CFG_W-1:0] cfg_sr;
  logic [CFG_W-1:0] next_cfg_sr;
  logic [2:0] cfg_bits;
  logic [2:0] next_cfg_bits;
  logic [CFG_W-1:0] next_active_cfg;
  logic [RESULT_W-1:0] hold;
  logic [RESULT_W-1:0] next_hold;
  logic [RESULT_W-1:0] result_sr;
  logic [RESULT_W-1:0] next_result_sr;
  logic [WAKE_W-1:0] wake_cnt;
  logic [WAKE_W-1:0] next_wake_cnt;
  logic next_bit;
  logic next_oe_n;
  logic next_done;
  logic [CFG_W-1:0] applied;

  // Sequencer next values
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cfg_sr = cfg_sr;
    next_cfg_bits = cfg_bits;
    next_active_cfg = active_cfg;
    next_hold = hold;
    next_result_sr = result_sr;
    next_wake_cnt = wake_cnt;
    next_done = 1'b0;
    // A part word keeps the old setting
    applied = (cfg_bits == 3'(CFG_W)) ? cfg_sr : active_cfg; // see R14
    if (wake_cnt != '0) begin
      next_wake_cnt = wake_cnt - 1'b1;
    end
    unique case (state)
      ST_CONV: begin
        // Busy: trigger edges and shift clock have no effect
        if (cnt == '0) begin // see R02 see R12
          next_done = 1'b1;
          next_result_sr = format_code(hold, active_cfg[CFG_UNI]); // see R03
          next_state = trig_hi ? ST_NAP : ST_ACQ; // see R06 see R07
        end else begin
          next_cnt = cnt - 1'b1; // see R04
        end
      end
      ST_ACQ, ST_NAP, ST_SLEEP: begin
        if (trig_rise) begin // see R01
          next_active_cfg = applied; // see R14
          next_cfg_bits = 3'h0;
          if (applied[CFG_SLP]) begin
            next_state = ST_SLEEP; // see R10
          end else begin
            next_state = ST_CONV;
            next_cnt = CNT_W'(CONV_TYP_CYC - 1); // see R04
            next_hold = analog_code;
            if (state == ST_SLEEP) begin
              next_wake_cnt = WAKE_W'(WAKE_CYC);
            end
          end
        end else if (!trig_hi) begin
          // Nap ends with the transfer; serial port open while low
          if (state == ST_NAP) begin
            next_state = ST_ACQ; // see R06
          end
          if (sck_rise && cfg_bits != 3'(CFG_W)) begin // see R17
            next_cfg_sr = {cfg_sr[CFG_W-2:0], cfg_bit}; // see R18
            next_cfg_bits = cfg_bits + 1'b1;
          end
          if (sck_fall) begin // see R17
            next_result_sr = {result_sr[RESULT_W-2:0], 1'b0}; // see R18
          end
        end
      end
    endcase
    // Released whenever trigger is high, low line while converting
    next_oe_n = trig_hi; // see R18 see R03
    // MSB shows at once at conversion end if trigger already low
    next_bit = (next_state == ST_CONV) ? 1'b0
      : next_result_sr[RESULT_W-1]; // see R07 see R09
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_ACQ;
      cnt <= '0;
      cfg_sr <= CFG_RESET;
      cfg_bits <= 3'h0;
      active_cfg <= CFG_RESET;
      hold <= RESULT_RESET;
      result_sr <= RESULT_RESET;
      wake_cnt <= '0;
      conv_done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cfg_sr <= next_cfg_sr;
      cfg_bits <= next_cfg_bits;
      active_cfg <= next_active_cfg;
      hold <= next_hold;
      result_sr <= next_result_sr;
      wake_cnt <= next_wake_cnt;
      conv_done <= next_done;
    end
  end

  // Pin and status flops, all from next values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.result_bit <= 1'b0;
      link.result_oe_n <= 1'b1;
      converting <= 1'b0;
      napping <= 1'b0;
      sleeping <= 1'b0;
      awake <= 1'b1;
    end else begin
      link.result_bit <= next_bit;
      link.result_oe_n <= next_oe_n;
      converting <= (next_state == ST_CONV);
      napping <= (next_state == ST_NAP);
      sleeping <= (next_state == ST_SLEEP);
      awake <= (next_state != ST_SLEEP) && (next_wake_cnt == '0);
    end
  end

endmodule

// [design/adc_host_end.sv]
// Purpose: Controller end: triggers, times and reads the converter.
// Assumes: Shift clock made here from a divider, period 16 cycles.
// Notes: Results during wake-up or from a dummy run are discarded.
`timescale 1ns/10ps
module adc_host_end
  import adc_seq_pkg::*;
#(
  parameter int unsigned WAKE_CYC = WAKE_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  adc_link_if.host link,
  input wire logic start,
  input wire logic [CFG_W-1:0] cfg_word,
  input wire logic short_pulse,
  output logic ready,
  output logic [RESULT_W-1:0] result,
  output logic result_valid,
  output logic conv_window
);

  typedef enum logic [1:0] {H_IDLE, H_CONV, H_XFER} host_state_t;

  // Result line synchroniser
  logic sdo_s1;
  logic sdo_s2;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdo_s1 <= 1'b0;
      sdo_s2 <= 1'b0;
    end else begin
      sdo_s1 <= link.serial_result_out;
      sdo_s2 <= sdo_s1;
    end
  end

  host_state_t state;
  host_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W-1:0] next_per_cnt;
  logic [4:0] bitn;
  logic [4:0] next_bitn;
  logic [CFG_W-1:0] tx_word;
  logic [CFG_W-1:0] next_tx_word;
  logic [CFG_W-1:0] sent_cfg;
  logic [CFG_W-1:0] next_sent_cfg;
  logic [RESULT_W-1:0] rx;
  logic [RESULT_W-1:0] next_rx;
  logic [WAKE_W-1:0] wake_cnt;
  logic [WAKE_W-1:0] next_wake_cnt;
  logic dummy_pend;
  logic next_dummy_pend;
  logic dev_asleep;
  logic next_dev_asleep;
  logic discard;
  logic next_discard;
  logic short_q;
  logic next_short_q;
  logic next_trig;
  logic next_sck;
  logic next_cfg;
  logic next_valid;
  logic [RESULT_W-1:0] next_result;

  // Sequencer next values
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_per_cnt = (per_cnt == PER_CNT_RESET) ? per_cnt : per_cnt + 1'b1;
    next_bitn = bitn;
    next_tx_word = tx_word;
    next_sent_cfg = sent_cfg;
    next_rx = rx;
    next_wake_cnt = (wake_cnt != '0) ? wake_cnt - 1'b1 : wake_cnt;
    next_dummy_pend = dummy_pend;
    next_dev_asleep = dev_asleep;
    next_discard = discard;
    next_short_q = short_q;
    next_trig = 1'b0;
    next_sck = 1'b0;
    next_cfg = 1'b0; // see R12
    next_valid = 1'b0;
    next_result = result;
    unique case (state)
      H_IDLE: begin
        // Spacing from last rise covers rate and acquisition
        if ((dummy_pend || (start && ready))
            && per_cnt >= CNT_W'(GAP_CYC)) begin // see R05 see R15
          next_state = H_CONV;
          next_trig = 1'b1; // see R01
          next_cnt = '0;
          next_per_cnt = '0;
          next_short_q = short_pulse;
          next_tx_word = cfg_word;
          next_dev_asleep = sent_cfg[CFG_SLP];
          next_discard = dummy_pend || sent_cfg[CFG_SLP] || wake_cnt != '0;
          if (dev_asleep && !sent_cfg[CFG_SLP]) begin
            next_wake_cnt = WAKE_W'(WAKE_CYC); // see R11
            next_discard = 1'b1;
          end
        end
      end
      H_CONV: begin
        // Early drop lands before the first bit decision
        next_trig = !(short_q
          && cnt >= CNT_W'(EARLY_LOW_CYC - 1)); // see R08
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(CONV_MAX_CYC - 1)) begin // see R04 see R13
          next_state = H_XFER;
          next_trig = 1'b0; // see R03
          next_cnt = '0;
          next_bitn = '0;
          next_sent_cfg = tx_word; // see R14
        end
      end
      H_XFER: begin
        next_cnt = cnt + 1'b1;
        next_cfg = (bitn < 5'(CFG_W))
          ? tx_word[3'(CFG_W - 1) - bitn[2:0]] : 1'b0; // see R18
        next_sck = (cnt >= CNT_W'(SCK_HALF_CYC - 1))
          && (cnt != CNT_W'(2 * SCK_HALF_CYC - 1)); // see R17
        if (cnt == CNT_W'(2 * SCK_HALF_CYC - 1)) begin
          // Sample at end of the high phase, before the fall
          next_rx = {rx[RESULT_W-2:0], sdo_s2}; // see R17 see R18
          next_cnt = '0;
          next_bitn = bitn + 1'b1;
          if (bitn == 5'(RESULT_W - 1)) begin
            next_state = H_IDLE;
            next_cfg = 1'b0;
            next_result = {rx[RESULT_W-2:0], sdo_s2};
            next_valid = !discard;
            if (dummy_pend) begin
              next_dummy_pend = 1'b0; // see R16
              next_wake_cnt = WAKE_W'(WAKE_CYC);
            end
          end
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= H_IDLE;
      cnt <= '0;
      per_cnt <= PER_CNT_RESET;
      bitn <= '0;
      tx_word <= CFG_RESET;
      sent_cfg <= CFG_RESET;
      rx <= RESULT_RESET;
      wake_cnt <= '0;
      dummy_pend <= 1'b1;
      dev_asleep <= 1'b0;
      discard <= 1'b0;
      short_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      per_cnt <= next_per_cnt;
      bitn <= next_bitn;
      tx_word <= next_tx_word;
      sent_cfg <= next_sent_cfg;
      rx <= next_rx;
      wake_cnt <= next_wake_cnt;
      dummy_pend <= next_dummy_pend;
      dev_asleep <= next_dev_asleep;
      discard <= next_discard;
      short_q <= next_short_q;
    end
  end

  // Pin and user-side flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.sample_trigger_n <= 1'b0;
      link.shift_clk <= 1'b0;
      link.serial_config_in <= 1'b0;
      ready <= 1'b0;
      result <= RESULT_RESET;
      result_valid <= 1'b0;
      conv_window <= 1'b0;
    end else begin
      link.sample_trigger_n <= next_trig;
      link.shift_clk <= next_sck;
      link.serial_config_in <= next_cfg;
      ready <= (next_state == H_IDLE) && (next_wake_cnt == '0)
        && !next_dummy_pend;
      result <= next_result;
      result_valid <= next_valid;
      conv_window <= (next_state == H_CONV); // see R13
    end
  end

endmodule

// [tb/adc_link_properties.sv]
// Purpose: Timing checks on the converter link pins.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Sees only interface signals, no design internals.
`timescale 1ns/10ps
module adc_link_properties
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_trigger_n,
  input wire logic shift_clk,
  input wire logic serial_config_in,
  input wire logic result_bit,
  input wire logic result_oe_n,
  input wire logic serial_result_out
);
  logic [7:0] hi_cnt, next_hi_cnt, gap_cnt, next_gap_cnt;
  logic trig_q, next_trig_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // High time and rise spacing, saturating so long idles stay legal
  always_comb begin
    next_trig_q = sample_trigger_n;
    next_hi_cnt = sample_trigger_n ? hi_cnt + {7'h00, hi_cnt != 8'hff} : 8'h00;
    next_gap_cnt = gap_cnt + {7'h00, gap_cnt != 8'hff};
    if (sample_trigger_n && !trig_q) begin
      next_gap_cnt = 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_cnt <= 8'h00;
      gap_cnt <= 8'hff;
      trig_q <= 1'b0;
    end else begin
      hi_cnt <= next_hi_cnt;
      gap_cnt <= next_gap_cnt;
      trig_q <= next_trig_q;
    end
  end

  oe_release_a: assert property (sample_trigger_n[*5] |-> result_oe_n)
    else $error("result line driven while trigger high");
  oe_drive_a: assert property ($fell(sample_trigger_n) ##1
    !sample_trigger_n[*4] |-> !result_oe_n)
    else $error("result line not driven with trigger low");
  sck_quiet_a: assert property (sample_trigger_n |-> !shift_clk)
    else $error("shift clock moved while trigger high");
  cfg_still_a: assert property (sample_trigger_n && $past(sample_trigger_n)
    |-> $stable(serial_config_in))
    else $error("config line moved during conversion");
  trig_pulse_a: assert property ($fell(sample_trigger_n) |->
    (hi_cnt == EARLY_LOW_CYC || hi_cnt >= CONV_MAX_CYC))
    else $error("trigger fell inside bit decisions");
  rise_gap_a: assert property ($rose(sample_trigger_n) |-> gap_cnt >= GAP_CYC)
    else $error("trigger rises too close together");
  sck_high_a: assert property ($rose(shift_clk) |-> shift_clk[*8] ##1 !shift_clk)
    else $error("shift clock high time wrong");
  data_hold_a: assert property (shift_clk && $past(shift_clk) |->
    $stable(result_bit))
    else $error("result bit changed while shift clock high");
  line_match_a: assert property (!result_oe_n |->
    serial_result_out == result_bit)
    else $error("result line differs from driven bit");
endmodule

// [tb/tb_top.sv]
// Purpose: Both link ends back to back, user sides driven here.
// Assumes: Wake wait shortened to 200 cycles on both ends.
// Notes: Results are predicted from the config word in force.
`timescale 1ns/10ps
module tb_top
  import adc_seq_pkg::*;
;
  localparam int unsigned WAKE_SIM = 200;
  logic clk, rst_n, start, short_pulse;
  logic [CFG_W-1:0] cfg_word, cfg_now;
  logic [RESULT_W-1:0] analog_code, result;
  logic ready, result_valid, conv_window;
  logic [CFG_W-1:0] active_cfg;
  logic converting, napping, sleeping, awake, conv_done;
  int miscompares, samples_checked;
  logic [RESULT_W-1:0] codes [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};

  adc_link_if u_adc_link_if ();
  adc_device_end #(.WAKE_CYC(WAKE_SIM)) u_adc_device_end (.clk(clk),
    .rst_n(rst_n), .link(u_adc_link_if), .analog_code(analog_code),
    .active_cfg(active_cfg), .converting(converting), .napping(napping),
    .sleeping(sleeping), .awake(awake), .conv_done(conv_done));
  adc_host_end #(.WAKE_CYC(WAKE_SIM)) u_adc_host_end (.clk(clk),
    .rst_n(rst_n), .link(u_adc_link_if), .start(start), .cfg_word(cfg_word),
    .short_pulse(short_pulse), .ready(ready), .result(result),
    .result_valid(result_valid), .conv_window(conv_window));
  adc_link_properties u_props (.clk(clk), .rst_n(rst_n),
    .sample_trigger_n(u_adc_link_if.sample_trigger_n),
    .shift_clk(u_adc_link_if.shift_clk),
    .serial_config_in(u_adc_link_if.serial_config_in),
    .result_bit(u_adc_link_if.result_bit),
    .result_oe_n(u_adc_link_if.result_oe_n),
    .serial_result_out(u_adc_link_if.serial_result_out));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic compare_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t flag got %b want %b", $time, got, exp);
    end
  endtask

  task automatic compare_word(input logic [RESULT_W-1:0] got,
    input logic [RESULT_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t word got %h want %h", $time, got, exp);
    end
  endtask

  // One request; chk marks a run whose result must come back
  task automatic conv(input logic [CFG_W-1:0] nxt, input logic sp,
    input logic [RESULT_W-1:0] code, input logic chk);
    int n;
    int nd;
    int nb;
    logic seen;
    logic pre;
    logic sck_q;
    logic [RESULT_W-1:0] got;
    logic [RESULT_W-1:0] exp;
    logic [CFG_W-1:0] sent;
    n = 0;
    pre = 1'b0;
    while (ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
      // Dummy and waking runs must not hand out a result
      if (result_valid === 1'b1) begin
        pre = 1'b1;
      end
    end
    compare_bit(n < 2000, 1'b1);
    compare_bit(pre, 1'b0);
    exp = cfg_now[CFG_UNI] ? code : code ^ BIPOLAR_FLIP;
    start = 1'b1;
    cfg_word = nxt;
    short_pulse = sp;
    analog_code = code;
    @(negedge clk);
    start = 1'b0;
    seen = 1'b0;
    got = RESULT_RESET;
    sent = CFG_RESET;
    n = 0;
    nd = 0;
    nb = 0;
    sck_q = 1'b0;
    while (!(ready === 1'b1 && n > 2) && n < 2000) begin
      @(negedge clk);
      n++;
      // Config bits as the converter sees them, first seven rises
      if (u_adc_link_if.shift_clk === 1'b1 && !sck_q && nb < CFG_W) begin
        sent = {sent[CFG_W-2:0], u_adc_link_if.serial_config_in};
        nb++;
      end
      sck_q = u_adc_link_if.shift_clk;
      // Window spans the host's maximum wait, then clears
      if (n == CONV_MAX_CYC - 1) begin
        compare_bit(conv_window, 1'b1);
      end
      if (n == CONV_MAX_CYC + 1) begin
        compare_bit(conv_window, 1'b0);
      end
      if (chk && n == 10) begin
        compare_bit(converting, 1'b1);
      end
      if (chk && nd != 0 && n == nd + 1) begin
        compare_bit(converting, 1'b0);
        compare_bit(napping, !sp);
        if (sp) begin
          compare_bit(u_adc_link_if.serial_result_out, exp[15]);
        end
      end
      if (conv_done === 1'b1) begin
        nd = n;
        if (chk) begin
          compare_bit(nd <= CONV_MAX_CYC, 1'b1);
          compare_word({9'h000, active_cfg}, {9'h000, cfg_now});
        end
      end
      if (result_valid === 1'b1) begin
        seen = 1'b1;
        got = result;
      end
    end
    compare_bit(n < 2000, 1'b1);
    compare_bit(seen, chk);
    if (chk) begin
      compare_word(got, exp);
      compare_word({9'h000, sent}, {9'h000, nxt});
    end
    cfg_now = nxt;
  endtask

  // Hang guard, far beyond the planned sequence
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    miscompares = 0;
    samples_checked = 0;
    cfg_now = CFG_RESET;
    rst_n = 1'b0;
    start = 1'b0;
    short_pulse = 1'b0;
    cfg_word = CFG_RESET;
    analog_code = RESULT_RESET;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    // Dummy run and wake wait happen before the first ready
    conv(7'h02, 1'b0, 16'h1234, 1'b1);
    for (int i = 0; i < 4; i++) begin
      conv(7'h02, 1'b1, codes[i], 1'b1);
    end
    conv(7'h00, 1'b1, 16'hc000, 1'b1);
    for (int i = 0; i < 4; i++) begin
      conv(7'h00, i[0], codes[i], 1'b1);
    end
    // Sleep word, then the rise that applies it, then the wake run
    conv(7'h01, 1'b0, 16'h1111, 1'b1);
    conv(7'h00, 1'b0, 16'h2222, 1'b0);
    compare_bit(sleeping, 1'b1);
    conv(7'h00, 1'b0, 16'h3333, 1'b0);
    compare_bit(sleeping, 1'b0);
    compare_bit(awake, 1'b1);
    conv(7'h00, 1'b1, 16'h0f0f, 1'b1);
    conclude();
  end
endmodule
